/* sim/dtx_exec_top_sva.sv */
// Port checks of the token execution unit
`timescale 1ns/100ps
module dtx_exec_sva
  import dtx_pkg::*;
(
  input wire logic        CLK_I,
  input wire logic        RESETN_I,
  input wire logic        AWVALID_I,
  input wire logic        AWREADY_O,
  input wire logic        WVALID_I,
  input wire logic        WREADY_O,
  input wire logic [1:0]  BRESP_O,
  input wire logic        BVALID_O,
  input wire logic        BREADY_I,
  input wire logic        ARVALID_I,
  input wire logic        ARREADY_O,
  input wire logic [31:0] RDATA_O,
  input wire logic [1:0]  RRESP_O,
  input wire logic        RVALID_O,
  input wire logic        RREADY_I,
  input wire dtx_tok_s    LT_TOK_O,
  input wire logic        LT_VALID_O,
  input wire logic        LT_READY_I
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESETN_I);

  tok_hold_a: assert property (LT_VALID_O && !LT_READY_I |=> LT_VALID_O && $stable(LT_TOK_O))
    else $error("Token changed while stalled");
  b_hold_a: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
    else $error("Write response dropped early");
  r_hold_a: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
    else $error("Read data dropped early");
  ar_ready_a: assert property (RVALID_O && RREADY_I |=> ARREADY_O)
    else $error("Read address ready wrong");
  r_answer_a: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
    else $error("Read answer late");
  b_answer_a: assert property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O && !BVALID_O
    |-> ##[1:3] BVALID_O)
    else $error("Write answer late");
  b_code_a: assert property (BVALID_O |-> BRESP_O inside {2'h0, 2'h2})
    else $error("Bad write response code");
  r_err_zero_a: assert property (RVALID_O && RRESP_O == 2'h2 |-> RDATA_O == 32'h0000_0000)
    else $error("Error read with data");
  reset_quiet_a: assert property ($rose(RESETN_I) |-> !LT_VALID_O && !BVALID_O && !RVALID_O)
    else $error("Output active after reset");
endmodule

bind dtx_exec_top dtx_exec_sva u_sva (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
  .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
  .BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .ARVALID_I(ARVALID_I),
  .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .RVALID_O(RVALID_O),
  .RREADY_I(RREADY_I), .LT_TOK_O(LT_TOK_O), .LT_VALID_O(LT_VALID_O), .LT_READY_I(LT_READY_I));

/* sim/dtx_lt_sink.sv */
// Link table model: takes generated tokens, promptly or with stalls
`timescale 1ns/100ps
module dtx_lt_sink
  import dtx_pkg::*;
(
  input  wire logic     clk_i,
  input  wire logic     resetn_i,
  input  wire dtx_tok_s tok_i,
  input  wire logic     valid_i,
  input  wire logic     slow_i,
  output logic          ready_o
);
  logic [1:0] phase_reg;
  dtx_tok_s   got[$];
  // Slow mode takes one token in four cycles, so bursts stall midway
  assign ready_o = !slow_i || (phase_reg == 2'h3);
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      phase_reg <= 2'h0;
    else
    begin
      phase_reg <= phase_reg + 2'h1;
      // Every taken token kept in order; mode tokens must never arrive
      if (valid_i && ready_o)
        got.push_back(tok_i);
    end
  end
endmodule

/* sim/testbench.sv */
// Self-checking bench of the token execution unit
`timescale 1ns/100ps
`include "dtx_cfg.svh"
module testbench
  import dtx_pkg::*;
();
  logic        clk = 1'b0, resetn = 1'b0, slow = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rdd;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp, br, rr;
  logic        awready, wready, bvalid, arready, rvalid, lt_valid, lt_ready;
  logic [13:0] g;
  dtx_tok_s    lt_tok;
  int          error_cnt = 0, check_count = 0, i, s;
  logic [15:0] msk [4] = '{16'hFFFF, 16'hFFFF, 16'h3FFF, 16'h03FF};
  // Rows: opcode, A, B, expected X, expected Y
  logic [76:0] rows [18] = '{
    {`DTX_OP_CCOPY, 18'h2_1234, 18'h1_5678, 18'h2_1234, 18'h3_5678},
    {`DTX_OP_BTEST, 18'h0_0010, 18'h0_00F4, 18'h0_0001, 18'h0_0000},
    {`DTX_OP_BTEST, 18'h2_0010, 18'h0_0003, 18'h2_0000, 18'h0_0000},
    {`DTX_OP_BSET, 18'h1_0000, 18'h0_000F, 18'h1_8000, 18'h0_0000},
    {`DTX_OP_BCLR, 18'h0_FFFF, 18'h0_0000, 18'h0_FFFE, 18'h0_0000},
    {`DTX_OP_AND_MASK_CHECK_OP, 18'h0_00FF, 18'h1_000F, 18'h2_00FF, 18'h3_000F},
    {`DTX_OP_AND_MASK_CHECK_OP, 18'h2_00F0, 18'h0_000F, 18'h0_00F0, 18'h0_000F},
    {`DTX_OP_OR_MASK_CHECK_OP, 18'h0_0F00, 18'h0_0100, 18'h2_0F00, 18'h2_0100},
    {`DTX_OP_OR_MASK_CHECK_OP, 18'h2_0F00, 18'h0_00FF, 18'h0_0F00, 18'h0_00FF},
    {`DTX_OP_TO2C, 18'h1_0005, 18'h0_0000, 18'h1_FFFB, 18'h0_0000},
    {`DTX_OP_TOSM, 18'h0_FFFB, 18'h0_0000, 18'h1_0005, 18'h0_0000},
    {`DTX_OP_ADJ, 18'h0_0005, 18'h1_0003, 18'h0_0004, 18'h0_FFFD},
    {`DTX_OP_ADJ, 18'h1_0005, 18'h1_0007, 18'h1_0005, 18'h1_0007},
    {`DTX_OP_ADJ, 18'h0_0005, 18'h1_0000, 18'h0_0005, 18'h0_0000},
    {`DTX_OP_ADJ, 18'h1_0005, 18'h0_0003, 18'h1_0004, 18'h1_FFFD},
    {`DTX_OP_ADJ, 18'h1_0000, 18'h0_0007, 18'h0_0000, 18'h0_0007},
    {`DTX_OP_ADD, 18'h0_8000, 18'h0_8000, 18'h0_0000, 18'h0_0001},
    {`DTX_OP_ADDN, 18'h0_0001, 18'h0_0002, 18'h0_0003, 18'h0_000E}};

  dtx_exec_top u_dut (.CLK_I(clk), .RESETN_I(resetn), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
    .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid),
    .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
    .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .LT_TOK_O(lt_tok),
    .LT_VALID_O(lt_valid), .LT_READY_I(lt_ready));
  dtx_lt_sink u_sink (.clk_i(clk), .resetn_i(resetn), .tok_i(lt_tok), .valid_i(lt_valid),
    .slow_i(slow), .ready_o(lt_ready));

  always #5 clk = ~clk;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task chkt(input dtx_tok_s got, input logic [25:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: token %h expected %h", $time, got, exp);
    end
  endtask
  // Address and data offered together; each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw || w)
    begin
      @(posedge clk);
      if (awready === 1'b1) aw = 1'b0;
      if (wready === 1'b1) w = 1'b0;
      awvalid <= aw;
      wvalid <= w;
    end
    while (bvalid !== 1'b1) @(posedge clk);
    // Late acceptance makes the response hold for a cycle
    bready <= 1'b1;
    @(posedge clk);
    br = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    @(posedge clk);
    while (arready !== 1'b1) @(posedge clk);
    arvalid <= 1'b0;
    @(posedge clk);
    while (rvalid !== 1'b1) @(posedge clk);
    rready <= 1'b1;
    @(posedge clk);
    rdd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  // k: 0 block (last id+1), 1 multiple (id+i), 2 fixed id; e: error expected
  task gen(input logic [13:0] gi, input logic [24:0] tk, input logic [16:0] st,
           input logic [17:0] w0, input int n, input int k, input int e);
    logic [6:0]  id;
    logic [15:0] d;
    int          j;
    u_sink.got.delete();
    wr(`DTX_OFS_GINSTR, {18'h0, gi});
    wr(`DTX_OFS_GTOK, {7'h0, tk});
    wr(`DTX_OFS_STEP, {15'h0, st});
    wr(`DTX_OFS_CTRL, 32'h0000_0002);
    if (e != 0) wr(`DTX_OFS_CTRL, 32'h0000_0002);
    j = 0;
    do
    begin
      rd(`DTX_OFS_STAT);
      j++;
    end while (rdd[0] !== 1'b0 && j < 200);
    chk(rdd, {30'h0, e[0], 1'b0});
    chk(u_sink.got.size(), n);
    for (j = 0; j < n && j < u_sink.got.size(); j++)
    begin
      id = tk[24:18] + 7'(k == 1 ? j : (k == 0 && j == n - 1));
      d = st[16] ? w0[15:0] - 16'(j) * st[15:0] : w0[15:0] + 16'(j) * st[15:0];
      chkt(u_sink.got[j], {gi[13], id, w0[17:16], d});
    end
    wr(`DTX_OFS_STAT, 32'h0000_0002);
  endtask
  task test_done;
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    test_done;
  end

  initial
  begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 11; i++)
    begin
      rd(8'(i * 4));
      chk(rdd, `DTX_RST_WORD);
    end
    rd(8'h40);
    chk(rdd, `DTX_RST_WORD);
    chk({30'h0, rr}, {30'h0, `DTX_RESP_SLVERR});
    wr(8'h44, 32'h0000_0001);
    chk({30'h0, br}, {30'h0, `DTX_RESP_SLVERR});
    wr(`DTX_OFS_X, 32'h0000_FFFF);
    rd(`DTX_OFS_X);
    chk(rdd, `DTX_RST_WORD);
    for (i = 0; i < 18; i++)
    begin
      wr(`DTX_OFS_A, {14'h0, rows[i][71:54]});
      wr(`DTX_OFS_B, {14'h0, rows[i][53:36]});
      wr(`DTX_OFS_OP, {27'h0, rows[i][76:72]});
      wr(`DTX_OFS_CTRL, 32'h0000_0001);
      rd(`DTX_OFS_X);
      chk(rdd, {14'h0, rows[i][35:18]});
      rd(`DTX_OFS_Y);
      chk(rdd, {14'h0, rows[i][17:0]});
    end
    gen(14'h0000, {7'h05, 18'h0_0100}, 17'h0_0001, 18'h0_0100, 2, 0, 0);
    slow <= 1'b1;
    gen(14'h23C0, {7'h10, 18'h2_0050}, 17'h1_0002, 18'h2_0050, 17, 0, 1);
    wr(`DTX_OFS_B, 32'h0003_0200);
    gen(14'h1440, {7'h20, 18'h0_0999}, 17'h0_0003, 18'h3_0200, 3, 1, 0);
    slow <= 1'b0;
    gen(14'h0C00, {7'h30, 18'h1_4444}, 17'h0_0000, 18'h1_4444, 2, 1, 0);
    gen(14'h0D00, {7'h30, 18'h1_4444}, 17'h0_0000, 18'h0_0000, 0, 0, 1);
    gen(14'h0800, {7'h30, 18'h1_4444}, 17'h0_0000, 18'h0_0000, 0, 0, 1);
    for (s = 0; s < 4; s++)
    begin
      g = 14'(s * 64);
      gen(14'h0F00 + g, {7'(s + 3), 18'h3_FFFF}, 17'h0, 18'h0, 0, 2, 0);
      gen(14'h0E00 + g, {7'(s + 3), 18'h0}, 17'h0, {2'h0, msk[s]}, 1, 2, 0);
    end
    test_done;
  end
endmodule

/* verilog/dtx_cfg.svh */
// Register map, field positions, opcodes and reset values of the token unit
`ifndef DTX_CFG_SVH
`define DTX_CFG_SVH
`define DTX_OFS_CTRL     8'h00
`define DTX_OFS_A        8'h04
`define DTX_OFS_B        8'h08
`define DTX_OFS_OP       8'h0C
`define DTX_OFS_X        8'h10
`define DTX_OFS_Y        8'h14
`define DTX_OFS_GINSTR   8'h18
`define DTX_OFS_GTOK     8'h1C
`define DTX_OFS_STEP     8'h20
`define DTX_OFS_STAT     8'h24
`define DTX_OFS_RDRES    8'h28
`define DTX_CTRL_PU_GO   0
`define DTX_CTRL_GEN_GO  1
`define DTX_GI_FL        13
`define DTX_GI_XCH       12
`define DTX_GI_OP_HI     11
`define DTX_GI_OP_LO     10
`define DTX_GI_SZ_HI     9
`define DTX_GI_SZ_LO     6
`define DTX_STEP_DOWN    16
`define DTX_STAT_BUSY    0
`define DTX_STAT_ERR     1
`define DTX_RST_WORD     32'h0000_0000
`define DTX_RESP_OKAY    2'h0
`define DTX_RESP_SLVERR  2'h2
`define DTX_OP_CCOPY     5'h13
`define DTX_OP_BTEST     5'h15
`define DTX_OP_BSET      5'h16
`define DTX_OP_BCLR      5'h17
`define DTX_OP_AND_MASK_CHECK_OP    5'h0D
`define DTX_OP_OR_MASK_CHECK_OP     5'h10
`define DTX_OP_TO2C      5'h0E
`define DTX_OP_TOSM      5'h0F
`define DTX_OP_ADJ       5'h14
`define DTX_OP_ADD       5'h18
`define DTX_OP_ADDN      5'h1C
`define DTX_GEN_BLOCK    2'h0
`define DTX_GEN_MULTI    2'h1
`define DTX_GEN_TABLE    2'h3
`define DTX_CODE_NORMAL  2'h0
`define DTX_CODE_WRITE   2'h3
`define DTX_CODE_READ    2'h2
`define DTX_COPY_EXTRA   5'h02
`endif

/* verilog/dtx_exec_top.sv */
// Token execution unit: processing unit, token generator and AXI4-Lite registers
//
// How it works
// - Control-bit copy: both controls take A control
// - Bit test gives 0001H if A bit set
// - Bit set/clear on A bit chosen by B
// - AND-mask check drives both control bits
// - OR-mask check drives both control bits
// - Convert A between sign-magnitude and two's complement
// - Adjust, opposite signs, nonzero: A-1, 0-B
// - Adjust: equal signs pass through; a zero half takes the other half's sign
// - Add reports overflow as 0001H on Y
// - Normalizing add gives leading zeros of X
// - Full/left flag marks standalone or paired use
// - Swap flag exchanges A and B sides
// - Size field gives 2 to 17 copies
// - Block copy: last copy carries identifier plus one
// - Block copy emits size+2 tokens to link table
// - Copies step data up or down by D
// - Multiple copy: size+2 tokens, distinct identifiers
// - Codes 1100/1101 write link or right table
// - Codes 1110/1111 write left or temporary field
// - Codes 10xx read a table entry, output it
// - Code 00xx acts as multiple copy; 01xx refused
`timescale 1ns/100ps
`include "dtx_cfg.svh"
module dtx_exec_top
  import dtx_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RESETN_I,
  input  wire logic [7:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [7:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  output dtx_tok_s         LT_TOK_O,
  output logic             LT_VALID_O,
  input  wire logic        LT_READY_I
);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction

  function automatic logic addr_known(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= `DTX_OFS_RDRES);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Declarations

  logic           aw_full_reg;
  logic [7:0]     aw_addr_reg;
  logic           w_full_reg;
  logic [31:0]    w_data_reg;
  logic [3:0]     w_strb_reg;
  logic           wr_commit;
  logic [31:0]    wr_old;
  logic [31:0]    wr_word;
  logic [31:0]    rd_word;
  logic           ctrl_wr;
  logic           pu_go;
  logic           gen_go;
  dtx_word_s      a_reg;
  dtx_word_s      b_reg;
  logic [4:0]     op_reg;
  dtx_word_s      x_reg;
  dtx_word_s      y_reg;
  dtx_word_s      pu_x;
  dtx_word_s      pu_y;
  logic [13:0]    gi_reg;
  logic [24:0]    gtok_reg;
  logic [16:0]    step_reg;
  logic           err_reg;
  logic [15:0]    rdres_reg;
  dtx_gen_state_e gst_reg;
  logic [4:0]     cnt_reg;
  logic           multi_reg;
  dtx_tok_s       out_reg;
  logic [1:0]     gi_op;
  logic [3:0]     gi_code;
  dtx_word_s      src_w;
  logic [6:0]     src_id;
  logic           start;
  logic           cp_start;
  logic           tw_start;
  logic           tr_start;
  logic           bad_start;
  logic           lt_take;
  logic [15:0]    tbl_rd_data;

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data held independently

  assign AWREADY_O = !aw_full_reg;
  assign WREADY_O  = !w_full_reg;
  // One response outstanding at a time; new writes wait for it
  assign wr_commit = aw_full_reg && w_full_reg && !BVALID_O;

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end
    else if (AWVALID_I && AWREADY_O)
    begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= AWADDR_I;
    end
    else if (wr_commit)
      aw_full_reg <= 1'b0;
  end

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      w_full_reg <= 1'b0;
      w_data_reg <= `DTX_RST_WORD;
      w_strb_reg <= 4'h0;
    end
    else if (WVALID_I && WREADY_O)
    begin
      w_full_reg <= 1'b1;
      w_data_reg <= WDATA_I;
      w_strb_reg <= WSTRB_I;
    end
    else if (wr_commit)
      w_full_reg <= 1'b0;
  end

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      BVALID_O <= 1'b0;
      BRESP_O  <= `DTX_RESP_OKAY;
    end
    else if (wr_commit)
    begin
      BVALID_O <= 1'b1;
      BRESP_O  <= addr_known(aw_addr_reg) ? `DTX_RESP_OKAY : `DTX_RESP_SLVERR;
    end
    else if (BREADY_I)
      BVALID_O <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // Register file

  always_comb
  begin
    unique case (aw_addr_reg)
      `DTX_OFS_A:      wr_old = {14'h0000, a_reg};
      `DTX_OFS_B:      wr_old = {14'h0000, b_reg};
      `DTX_OFS_OP:     wr_old = {27'h000_0000, op_reg};
      `DTX_OFS_GINSTR: wr_old = {18'h0_0000, gi_reg};
      `DTX_OFS_GTOK:   wr_old = {7'h00, gtok_reg};
      `DTX_OFS_STEP:   wr_old = {15'h0000, step_reg};
      default:         wr_old = `DTX_RST_WORD;
    endcase
  end

  assign wr_word = merge_bytes(wr_old, w_data_reg, w_strb_reg);
  assign ctrl_wr = wr_commit && aw_addr_reg == `DTX_OFS_CTRL && w_strb_reg[0];
  assign pu_go   = ctrl_wr && w_data_reg[`DTX_CTRL_PU_GO];
  assign gen_go  = ctrl_wr && w_data_reg[`DTX_CTRL_GEN_GO];

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      a_reg    <= '0;
      b_reg    <= '0;
      op_reg   <= 5'h00;
      gi_reg   <= 14'h0000;
      gtok_reg <= 25'h000_0000;
      step_reg <= 17'h0_0000;
    end
    else if (wr_commit)
    begin
      unique case (aw_addr_reg)
        `DTX_OFS_A:      a_reg    <= dtx_word_s'(wr_word[17:0]);
        `DTX_OFS_B:      b_reg    <= dtx_word_s'(wr_word[17:0]);
        `DTX_OFS_OP:     op_reg   <= wr_word[4:0];
        `DTX_OFS_GINSTR: gi_reg   <= wr_word[13:0];
        `DTX_OFS_GTOK:   gtok_reg <= wr_word[24:0];
        `DTX_OFS_STEP:   step_reg <= wr_word[16:0];
        default:         a_reg    <= a_reg;
      endcase
    end
  end

  // Results are sampled only on a go pulse, so operand edits never disturb them
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      x_reg <= '0;
      y_reg <= '0;
    end
    else if (pu_go)
    begin
      x_reg <= pu_x;
      y_reg <= pu_y;
    end
  end

  dtx_pu u_pu
  (
    .op_i (op_reg),
    .a_i  (a_reg),
    .b_i  (b_reg),
    .x_o  (pu_x),
    .y_o  (pu_y)
  );

  // Error is sticky; a new fault in the clearing cycle keeps it set
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      err_reg <= 1'b0;
    else if (bad_start || (gen_go && gst_reg != GEN_IDLE))
      err_reg <= 1'b1;
    else if (wr_commit && aw_addr_reg == `DTX_OFS_STAT && w_strb_reg[0]
             && w_data_reg[`DTX_STAT_ERR])
      err_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  always_comb
  begin
    unique case (ARADDR_I)
      `DTX_OFS_A:      rd_word = {14'h0000, a_reg};
      `DTX_OFS_B:      rd_word = {14'h0000, b_reg};
      `DTX_OFS_OP:     rd_word = {27'h000_0000, op_reg};
      `DTX_OFS_X:      rd_word = {14'h0000, x_reg};
      `DTX_OFS_Y:      rd_word = {14'h0000, y_reg};
      `DTX_OFS_GINSTR: rd_word = {18'h0_0000, gi_reg};
      `DTX_OFS_GTOK:   rd_word = {7'h00, gtok_reg};
      `DTX_OFS_STEP:   rd_word = {15'h0000, step_reg};
      `DTX_OFS_STAT:   rd_word = {19'h0_0000, cnt_reg, 6'h00, err_reg,
                                  gst_reg != GEN_IDLE};
      `DTX_OFS_RDRES:  rd_word = {16'h0000, rdres_reg};
      default:         rd_word = `DTX_RST_WORD;
    endcase
  end

  assign ARREADY_O = !RVALID_O;

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      RVALID_O <= 1'b0;
      RDATA_O  <= `DTX_RST_WORD;
      RRESP_O  <= `DTX_RESP_OKAY;
    end
    else if (ARVALID_I && ARREADY_O)
    begin
      RVALID_O <= 1'b1;
      RDATA_O  <= rd_word;
      RRESP_O  <= addr_known(ARADDR_I) ? `DTX_RESP_OKAY : `DTX_RESP_SLVERR;
    end
    else if (RREADY_I)
      RVALID_O <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // Token generator command decode

  assign gi_op   = gi_reg[`DTX_GI_OP_HI:`DTX_GI_OP_LO];
  assign gi_code = gi_reg[`DTX_GI_SZ_HI:`DTX_GI_SZ_LO];
  assign src_id  = gtok_reg[24:18];
  // A side is the token register, B side the B operand
  assign src_w   = gi_reg[`DTX_GI_XCH] ? b_reg
                                        : dtx_word_s'(gtok_reg[17:0]);
  assign start   = gen_go && gst_reg == GEN_IDLE;

  always_comb
  begin
    cp_start = 1'b0;
    tw_start = 1'b0;
    tr_start = 1'b0;
    unique case (gi_op)
      `DTX_GEN_BLOCK, `DTX_GEN_MULTI: cp_start = start;
      `DTX_GEN_TABLE:
      begin
        cp_start = start && gi_code[3:2] == `DTX_CODE_NORMAL;
        tw_start = start && gi_code[3:2] == `DTX_CODE_WRITE;
        tr_start = start && gi_code[3:2] == `DTX_CODE_READ;
      end
      default: cp_start = 1'b0;
    endcase
  end

  // Operation 10 and codes 01xx belong to mode tokens and are refused
  assign bad_start = start && !(cp_start || tw_start || tr_start);

  ////////////////////////////////////////////////////////////////////
  // Token generator sequencer

  assign LT_VALID_O = gst_reg == GEN_EMIT;
  assign LT_TOK_O   = out_reg;
  assign lt_take    = LT_VALID_O && LT_READY_I;

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      gst_reg   <= GEN_IDLE;
      cnt_reg   <= 5'h00;
      multi_reg <= 1'b0;
      out_reg   <= '0;
      rdres_reg <= 16'h0000;
    end
    else
    begin
      unique case (gst_reg)
        GEN_IDLE:
        begin
          if (cp_start)
          begin
            gst_reg   <= GEN_EMIT;
            cnt_reg   <= {1'b0, gi_code} + `DTX_COPY_EXTRA;
            multi_reg <= gi_op != `DTX_GEN_BLOCK;
            out_reg   <= '{paired: gi_reg[`DTX_GI_FL],
                           id: src_id, w: src_w};
          end
          else if (tr_start)
          begin
            gst_reg <= GEN_READ;
            cnt_reg <= 5'h01;
          end
        end
        GEN_READ:
        begin
          gst_reg   <= GEN_EMIT;
          rdres_reg <= tbl_rd_data;
          out_reg   <= '{paired: gi_reg[`DTX_GI_FL], id: src_id,
                         w: '{c: 1'b0, s: 1'b0, data: tbl_rd_data}};
        end
        GEN_EMIT:
        begin
          if (lt_take)
          begin
            cnt_reg <= cnt_reg - 5'h01;
            if (cnt_reg == 5'h01)
              gst_reg <= GEN_IDLE;
            out_reg.w.data <= step_reg[`DTX_STEP_DOWN]
                              ? out_reg.w.data - step_reg[15:0]
                              : out_reg.w.data + step_reg[15:0];
            if (multi_reg || cnt_reg == 5'h02)
              out_reg.id <= out_reg.id + 7'h01;
          end
        end
      endcase
    end
  end

  // Writes commit at the start edge; the unit stays idle-only, so any later
  // read is issued after the write has landed
  dtx_tables u_tables
  (
    .clk_i     (CLK_I),
    .resetn_i  (RESETN_I),
    .wr_en_i   (tw_start),
    .wr_sel_i  (gi_code[1:0]),
    .wr_addr_i (src_id),
    .wr_data_i (src_w.data),
    .rd_en_i   (tr_start),
    .rd_sel_i  (gi_code[1:0]),
    .rd_addr_i (src_id),
    .rd_data_o (tbl_rd_data)
  );
endmodule

/* verilog/dtx_pkg.sv */
// Types shared by the token execution unit
package dtx_pkg;
  typedef struct packed {
    logic        c;
    logic        s;
    logic [15:0] data;
  } dtx_word_s;

  typedef struct packed {
    logic        paired;
    logic [6:0]  id;
    dtx_word_s   w;
  } dtx_tok_s;

  typedef enum logic [1:0] {
    GEN_IDLE,
    GEN_EMIT,
    GEN_READ
  } dtx_gen_state_e;
endpackage

/* verilog/dtx_pu.sv */
// Combinational processing unit: bit, check, conversion, adjust and add operations
`timescale 1ns/100ps
`include "dtx_cfg.svh"
module dtx_pu
  import dtx_pkg::*;
(
  input  wire logic [4:0] op_i,
  input  wire dtx_word_s  a_i,
  input  wire dtx_word_s  b_i,
  output dtx_word_s       x_o,
  output dtx_word_s       y_o
);

  function automatic logic [15:0] lead_zeros(input logic [15:0] v);
    logic [15:0] n;
    logic        hit;
    n   = 16'h0000;
    hit = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      if (v[i])
        hit = 1'b1;
      else if (!hit)
        n = n + 16'h0001;
    end
    return n;
  endfunction

  logic [3:0]  idx;
  logic [16:0] sum;
  logic        hit;

  always_comb
  begin
    idx = b_i.data[3:0];
    sum = {1'b0, a_i.data} + {1'b0, b_i.data};
    hit = 1'b0;
    x_o = a_i;
    y_o = b_i;
    case (op_i)
      `DTX_OP_CCOPY: y_o.c = a_i.c;
      `DTX_OP_BTEST:
      begin
        x_o.data = {15'h0000, a_i.data[idx]};
        y_o = '{c: b_i.c, s: 1'b0, data: 16'h0000};
      end
      `DTX_OP_BSET, `DTX_OP_BCLR:
      begin
        x_o.data[idx] = (op_i == `DTX_OP_BSET);
        y_o = '{c: b_i.c, s: 1'b0, data: 16'h0000};
      end
      `DTX_OP_AND_MASK_CHECK_OP, `DTX_OP_OR_MASK_CHECK_OP:
      begin
        // AND mask: all mask bits set; OR mask: any mask bit set
        hit = (op_i == `DTX_OP_AND_MASK_CHECK_OP) ? ((a_i.data & b_i.data) == b_i.data)
                                        : |(a_i.data & b_i.data);
        x_o.c = hit;
        y_o.c = hit;
      end
      `DTX_OP_TO2C, `DTX_OP_TOSM:
      begin
        x_o.s = (op_i == `DTX_OP_TO2C) ? a_i.s : a_i.data[15];
        x_o.data = x_o.s ? 16'h0000 - a_i.data : a_i.data;
        y_o = '{c: b_i.c, s: 1'b0, data: 16'h0000};
      end
      `DTX_OP_ADJ:
      begin
        if (a_i.s != b_i.s)
        begin
          if (a_i.data != 16'h0000 && b_i.data != 16'h0000)
          begin
            x_o.data = a_i.data - 16'h0001;
            y_o.data = 16'h0000 - b_i.data;
            // Both halves of the adjusted pair carry the upper word's sign
            y_o.s    = a_i.s;
          end
          else if (b_i.data == 16'h0000)
            y_o.s = a_i.s;
          else
            x_o.s = b_i.s;
        end
      end
      `DTX_OP_ADD, `DTX_OP_ADDN:
      begin
        if (a_i.s == b_i.s)
          x_o.data = sum[15:0];
        else if (a_i.data >= b_i.data)
          x_o.data = a_i.data - b_i.data;
        else
        begin
          x_o.s = b_i.s;
          x_o.data = b_i.data - a_i.data;
        end
        y_o.s = x_o.s;
        if (op_i == `DTX_OP_ADDN)
          y_o.data = lead_zeros(x_o.data);
        else
          y_o.data = {15'h0000, (a_i.s == b_i.s) & sum[16]};
      end
      default:
      begin
        x_o = a_i;
        y_o = b_i;
      end
    endcase
  end
endmodule

/* verilog/dtx_tables.sv */
// Link table and function table memories, one write and one read port
`timescale 1ns/100ps
`include "dtx_cfg.svh"
module dtx_tables
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        wr_en_i,
  input  wire logic [1:0]  wr_sel_i,
  input  wire logic [6:0]  wr_addr_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic        rd_en_i,
  input  wire logic [1:0]  rd_sel_i,
  input  wire logic [6:0]  rd_addr_i,
  output logic      [15:0] rd_data_o
);
  logic [15:0] link_mem [128];
  logic [15:0] ft_right [128];
  logic [13:0] ft_left  [128];
  logic [9:0]  ft_temp  [128];

  // Select 00 link, 01 right, 10 left (14 bits), 11 temporary (10 bits)
  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      unique case (wr_sel_i)
        2'h0: link_mem[wr_addr_i] <= wr_data_i;
        2'h1: ft_right[wr_addr_i] <= wr_data_i;
        2'h2: ft_left[wr_addr_i]  <= wr_data_i[13:0];
        2'h3: ft_temp[wr_addr_i]  <= wr_data_i[9:0];
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rd_data_o <= 16'h0000;
    else if (rd_en_i)
    begin
      unique case (rd_sel_i)
        2'h0: rd_data_o <= link_mem[rd_addr_i];
        2'h1: rd_data_o <= ft_right[rd_addr_i];
        2'h2: rd_data_o <= {2'h0, ft_left[rd_addr_i]};
        2'h3: rd_data_o <= {6'h00, ft_temp[rd_addr_i]};
      endcase
    end
  end
endmodule
